//--- ldr_pkg.sv
package ldr_pkg;

  // Clock and channel count
  localparam int CLK_HZ       = 20_000_000;
  localparam int NS_PER_CYC   = 1_000_000_000 / CLK_HZ;
  localparam int NCH          = 16;
  localparam int CNT_W        = 17;

  // Chopping period: shared counter runs 0 .. 4094
  localparam logic [11:0] PERIOD_STEPS = 12'h0FFF;
  localparam int CHOP_HZ_0 = 220;
  localparam int CHOP_HZ_1 = 250;
  localparam int CHOP_HZ_2 = 280;
  localparam int CHOP_HZ_3 = 330;
  localparam logic [4:0] STEP_DIV_0 = 5'(CLK_HZ / (CHOP_HZ_0 * 4095));
  localparam logic [4:0] STEP_DIV_1 = 5'(CLK_HZ / (CHOP_HZ_1 * 4095));
  localparam logic [4:0] STEP_DIV_2 = 5'(CLK_HZ / (CHOP_HZ_2 * 4095));
  localparam logic [4:0] STEP_DIV_3 = 5'(CLK_HZ / (CHOP_HZ_3 * 4095));

  // Refresh prescaler on the step clock
  localparam logic [2:0] REFRESH_PRESCALE_LAST = 3'h7;

  // Time figures and derived cycle or step counts
  localparam int STEP_NS        = 1000;
  localparam int STAGGER_NS     = 40_000;
  localparam int STAGGER_STEPS  = STAGGER_NS / STEP_NS;
  localparam int OPEN_TIME_NS   = 4_000_000;
  localparam int OPEN_CYC       = (OPEN_TIME_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int HICCUP_NS      = 1_000_000;
  localparam int HICCUP_CYC     = (HICCUP_NS + NS_PER_CYC - 1) / NS_PER_CYC;
  localparam int PROBE_NS       = 20_000;
  localparam int PROBE_CYC      = (PROBE_NS + NS_PER_CYC - 1) / NS_PER_CYC;

  // Register indices (byte address is four times the index)
  localparam logic [5:0] IDX_CHOP     = 6'h00;
  localparam logic [5:0] IDX_CTRL     = 6'h01;
  localparam logic [5:0] IDX_RF_LO    = 6'h02;
  localparam logic [5:0] IDX_RF_HI    = 6'h03;
  localparam logic [5:0] IDX_CHEN_HI  = 6'h04;
  localparam logic [5:0] IDX_CHEN_LO  = 6'h05;
  localparam logic [5:0] IDX_OPEN_HI  = 6'h06;
  localparam logic [5:0] IDX_OPEN_LO  = 6'h07;
  localparam logic [5:0] IDX_SHORT_HI = 6'h08;
  localparam logic [5:0] IDX_SHORT_LO = 6'h09;
  localparam int         IDX_CH_BASE  = 'h0A;
  localparam int         CH_STRIDE    = 3;

  // Control register field positions
  localparam int CTRL_EN       = 0;
  localparam int CTRL_STAGGER  = 1;
  localparam int CTRL_RAMP_LSB = 2;
  localparam int CTRL_STH_LSB  = 4;
  localparam int CTRL_LATCH    = 6;
  localparam int CTRL_FAULT_INDICATE_ENABLE    = 7;
  localparam int OTP_FLAG_BIT  = 2;

  // Values after reset
  localparam logic [1:0]  RST_CHOP    = 2'h1;
  localparam logic [7:0]  RST_CTRL    = 8'h00;
  localparam logic [9:0]  RST_REFRESH = 10'h1A9;
  localparam logic [15:0] RST_CHEN    = 16'hFFFF;
  localparam logic [5:0]  RST_AMP     = 6'h3F;
  localparam logic [11:0] RST_DUTY    = 12'h0FFF;

  // Bus slave phases
  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} ldr_bus_t;

  // Analog side inputs
  typedef struct packed {
    logic [NCH-1:0] open_cmp;
    logic [NCH-1:0] short_cmp;
    logic           otp;
  } ldr_fault_in_t;

  // Drive towards the current sinks
  typedef struct packed {
    logic [NCH-1:0]      gate;
    logic [NCH-1:0][5:0] amp;
    logic [1:0]          ramp_sel;
    logic [1:0]          short_thr_sel;
  } ldr_drive_t;

endpackage

//--- ldr_ctrl.sv
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Channels run only after global enable set
// - Cleared channel enable bit switches channel off
// - Six-bit amplitude code; zero gives zero current
// - Duty code over 4095; zero keeps off
// - Duty commits only on upper byte write
// - Two-bit field selects 220/250/280/330 Hz
// - Stagger delays each channel 40us after previous; code delays 40 steps, 28 to 44us depending on rate
// - Indicate disabled: shared pin keeps refresh wave
// - Indicate enabled: fault pulls shared pin low
// - Refresh count zero releases pin, else rectangle
// - Refresh rate 127500/count scaled by rate/250
// - Refresh count commits on upper byte write
// - Refresh counter clocked from step clock over eight
// - Ramp field sets rise and fall time
// - Protection sets flag, pulls fault output low
// - Retry mode releases fault when conditions clear
// - Latch mode releases fault after flags read
// - Latch mode keeps faulted channel off
// - Retry mode probes faulted channel 20us per ms
// - Open fault after 4ms continuous comparator indication
// - Fault flags clear on read
module ldr_ctrl #(
  parameter int OPEN_LIMIT   = ldr_pkg::OPEN_CYC,
  parameter int HICCUP_LIMIT = ldr_pkg::HICCUP_CYC
) (
  // Clock, reset and enable pin
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic                  en_pin,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  // Analog side
  input  wire ldr_pkg::ldr_fault_in_t fault_in,
  output ldr_pkg::ldr_drive_t        drive,
  // Open-drain pins
  output logic                       refresh_or_fault_pin_o,
  output logic                       refresh_or_fault_pin_oe,
  output logic                       fault_out_n_o,
  output logic                       fault_out_n_oe
);
  import ldr_pkg::*;

  typedef struct packed {
    ldr_bus_t              bus;
    logic [5:0]            addr_idx;
    logic                  wr;
    logic [31:0]           rdata;
    logic [1:0]            chop_rate_select;
    logic [7:0]            ctrl;
    logic [1:0]            rf_lo_shadow;
    logic [9:0]            refresh_count;
    logic [NCH-1:0]        channel_on_bit;
    logic [NCH-1:0]        open_flag;
    logic [NCH-1:0]        short_flag;
    logic                  otp_flag;
    logic [NCH-1:0][5:0]   amplitude_code;
    logic [NCH-1:0][11:0]  duty_code;
    logic [NCH-1:0][3:0]   duty_lo_shadow;
    logic [4:0]            step_div;
    logic [11:0]           period;
    logic [2:0]            pre8;
    logic [9:0]            rcnt;
    logic [NCH-1:0][CNT_W-1:0] open_cnt;
    logic [NCH-1:0][CNT_W-1:0] short_cnt;
    logic [NCH-1:0]        faulted;
    logic [CNT_W-1:0]      hic_cnt;
    logic [NCH-1:0]        gate;
    logic                  rf_low;
    logic                  flt_low;
  } ldr_state_t;

  ldr_state_t q_reg;
  ldr_state_t q_next;

  // Constant state after reset or enable pin low
  function automatic ldr_state_t rst_state();
    ldr_state_t r;
    r                  = '0;
    r.bus              = BUS_IDLE;
    r.chop_rate_select = RST_CHOP;
    r.ctrl             = RST_CTRL;
    r.rf_lo_shadow     = RST_REFRESH[1:0];
    r.refresh_count    = RST_REFRESH;
    r.channel_on_bit   = RST_CHEN;
    for (int i = 0; i < NCH; i++) begin
      r.amplitude_code[i] = RST_AMP;
      r.duty_code[i]      = RST_DUTY;
      r.duty_lo_shadow[i] = RST_DUTY[3:0];
    end
    return r;
  endfunction

  // Next-state logic
  always_comb begin
    logic        acc;
    logic        step_tick;
    logic        ref_tick;
    logic [4:0]  div_last;
    logic [7:0]  rd;
    logic [7:0]  wd;
    logic [11:0] off;
    logic [11:0] phase;
    logic        probe;
    logic        probe_end;
    logic        drive_on;
    logic        rect_high;
    logic        fault_act;
    logic        latch;
    logic [NCH-1:0] open_clr;
    logic [NCH-1:0] short_clr;
    logic        otp_clr;
    acc       = hsel & htrans[1] & hready;
    step_tick = 1'b0;
    ref_tick  = 1'b0;
    div_last  = 5'h0;
    rd        = 8'h00;
    wd        = hwdata[7:0];
    off       = 12'h000;
    phase     = 12'h000;
    probe     = 1'b0;
    probe_end = 1'b0;
    drive_on  = 1'b0;
    rect_high = 1'b1;
    fault_act = 1'b0;
    latch     = q_reg.ctrl[CTRL_LATCH];
    open_clr  = '0;
    short_clr = '0;
    otp_clr   = 1'b0;
    q_next    = q_reg;

    // Bus slave: one wait state so read data comes from a flop
    case (q_reg.bus)
      BUS_IDLE: begin
        if (acc) begin
          q_next.addr_idx = haddr[7:2];
          q_next.wr       = hwrite;
          q_next.bus      = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        q_next.bus = BUS_DONE;
        if (q_reg.wr) begin
          case (q_reg.addr_idx)
            IDX_CHOP:    q_next.chop_rate_select = wd[1:0];
            IDX_CTRL:    q_next.ctrl = wd;
            IDX_RF_LO:   q_next.rf_lo_shadow = wd[1:0];
            IDX_RF_HI:   q_next.refresh_count = {wd, q_reg.rf_lo_shadow};
            IDX_CHEN_HI: q_next.channel_on_bit[15:8] = wd;
            IDX_CHEN_LO: q_next.channel_on_bit[7:0] = wd;
            default: ;
          endcase
          for (int i = 0; i < NCH; i++) begin
            if (q_reg.addr_idx == 6'(IDX_CH_BASE + CH_STRIDE * i)) begin
              q_next.amplitude_code[i] = wd[5:0];
            end
            if (q_reg.addr_idx == 6'(IDX_CH_BASE + CH_STRIDE * i + 1)) begin
              q_next.duty_lo_shadow[i] = wd[3:0];
            end
            if (q_reg.addr_idx == 6'(IDX_CH_BASE + CH_STRIDE * i + 2)) begin
              q_next.duty_code[i] = {wd, q_reg.duty_lo_shadow[i]};
            end
          end
        end else begin
          case (q_reg.addr_idx)
            IDX_CHOP:     rd = {6'h00, q_reg.chop_rate_select};
            IDX_CTRL:     rd = q_reg.ctrl;
            IDX_RF_LO: begin
              rd      = {5'h00, q_reg.otp_flag, q_reg.rf_lo_shadow};
              otp_clr = 1'b1;
            end
            IDX_RF_HI:    rd = q_reg.refresh_count[9:2];
            IDX_CHEN_HI:  rd = q_reg.channel_on_bit[15:8];
            IDX_CHEN_LO:  rd = q_reg.channel_on_bit[7:0];
            IDX_OPEN_HI: begin
              rd             = q_reg.open_flag[15:8];
              open_clr[15:8] = 8'hFF;
            end
            IDX_OPEN_LO: begin
              rd            = q_reg.open_flag[7:0];
              open_clr[7:0] = 8'hFF;
            end
            IDX_SHORT_HI: begin
              rd              = q_reg.short_flag[15:8];
              short_clr[15:8] = 8'hFF;
            end
            IDX_SHORT_LO: begin
              rd             = q_reg.short_flag[7:0];
              short_clr[7:0] = 8'hFF;
            end
            default: rd = 8'h00;
          endcase
          for (int i = 0; i < NCH; i++) begin
            if (q_reg.addr_idx == 6'(IDX_CH_BASE + CH_STRIDE * i)) begin
              rd = {2'b00, q_reg.amplitude_code[i]};
            end
            if (q_reg.addr_idx == 6'(IDX_CH_BASE + CH_STRIDE * i + 1)) begin
              rd = {4'h0, q_reg.duty_lo_shadow[i]};
            end
            if (q_reg.addr_idx == 6'(IDX_CH_BASE + CH_STRIDE * i + 2)) begin
              rd = q_reg.duty_code[i][11:4];
            end
          end
          q_next.rdata = {24'h00_0000, rd};
        end
      end
      BUS_DONE: begin
        q_next.bus = BUS_IDLE;
        if (acc) begin
          q_next.addr_idx = haddr[7:2];
          q_next.wr       = hwrite;
          q_next.bus      = BUS_WAIT;
        end
      end
      default: q_next.bus = BUS_IDLE;
    endcase

    // Step clock divider follows the selected chopping rate
    case (q_reg.chop_rate_select)
      2'b00:   div_last = STEP_DIV_0 - 5'h1;
      2'b01:   div_last = STEP_DIV_1 - 5'h1;
      2'b10:   div_last = STEP_DIV_2 - 5'h1;
      default: div_last = STEP_DIV_3 - 5'h1;
    endcase
    if (q_reg.step_div >= div_last) begin
      q_next.step_div = 5'h0;
      step_tick       = 1'b1;
    end else begin
      q_next.step_div = q_reg.step_div + 5'h1;
    end

    // Shared period counter, 4095 steps per chopping period
    if (step_tick) begin
      q_next.period = (q_reg.period >= PERIOD_STEPS - 12'h1) ? 12'h000
                      : q_reg.period + 12'h1;
      q_next.pre8   = q_reg.pre8 + 3'h1;
      ref_tick      = (q_reg.pre8 == REFRESH_PRESCALE_LAST);
    end

    // Refresh counter: step clock over eight, count sets the period
    if (q_reg.refresh_count == 10'h000) begin
      q_next.rcnt = 10'h000;
      rect_high   = 1'b1;
    end else begin
      if (ref_tick) begin
        q_next.rcnt = (q_reg.rcnt >= q_reg.refresh_count - 10'h1) ? 10'h000
                      : q_reg.rcnt + 10'h1;
      end
      rect_high = (q_reg.rcnt < 10'((11'(q_reg.refresh_count) + 11'h1) >> 1));
    end

    // Hiccup timer: probe window opens each millisecond
    q_next.hic_cnt = (q_reg.hic_cnt >= CNT_W'(HICCUP_LIMIT - 1)) ? '0
                     : q_reg.hic_cnt + CNT_W'(1);
    probe     = (q_reg.hic_cnt < CNT_W'(PROBE_CYC));
    probe_end = (q_reg.hic_cnt == CNT_W'(PROBE_CYC - 1));

    // Per-channel gate and fault detection
    for (int i = 0; i < NCH; i++) begin
      off   = q_reg.ctrl[CTRL_STAGGER] ? 12'(STAGGER_STEPS * i) : 12'h000;
      phase = (q_reg.period >= off) ? q_reg.period - off
              : q_reg.period + PERIOD_STEPS - off;
      drive_on = q_reg.ctrl[CTRL_EN]
                 & q_reg.channel_on_bit[i]
                 & ~fault_in.otp
                 & (~q_reg.faulted[i] | (~latch & probe));
      q_next.gate[i] = drive_on & (q_reg.duty_code[i] != 12'h000)
                       & (phase < q_reg.duty_code[i]);

      // Persistence counters restart when the comparator drops
      if (fault_in.open_cmp[i] & drive_on & ~q_reg.faulted[i]) begin
        if (q_reg.open_cnt[i] >= CNT_W'(OPEN_LIMIT - 1)) begin
          q_next.open_cnt[i] = '0;
          q_next.faulted[i]  = 1'b1;
        end else begin
          q_next.open_cnt[i] = q_reg.open_cnt[i] + CNT_W'(1);
        end
      end else begin
        q_next.open_cnt[i] = '0;
      end
      if (fault_in.short_cmp[i] & drive_on & ~q_reg.faulted[i]) begin
        if (q_reg.short_cnt[i] >= CNT_W'(OPEN_LIMIT - 1)) begin
          q_next.short_cnt[i] = '0;
          q_next.faulted[i]   = 1'b1;
        end else begin
          q_next.short_cnt[i] = q_reg.short_cnt[i] + CNT_W'(1);
        end
      end else begin
        q_next.short_cnt[i] = '0;
      end

      // In retry mode, probe end with both comparators quiet clears the fault
      if (~latch & q_reg.faulted[i] & probe_end & ~fault_in.open_cmp[i]
          & ~fault_in.short_cmp[i]) begin
        q_next.faulted[i] = 1'b0;
      end
    end

    // Flags: a new event wins over a clear by read
    q_next.open_flag = (q_reg.open_flag & ~open_clr)
                       | (fault_in.open_cmp & ~q_reg.faulted
                          & q_next.faulted);
    q_next.short_flag = (q_reg.short_flag & ~short_clr)
                        | (fault_in.short_cmp & ~q_reg.faulted
                           & q_next.faulted & ~fault_in.open_cmp);
    q_next.otp_flag = (q_reg.otp_flag & ~otp_clr) | fault_in.otp;

    // Fault output: latch waits for reads, retry for conditions
    if (latch) begin
      fault_act = (|q_reg.open_flag) | (|q_reg.short_flag) | q_reg.otp_flag
                  | fault_in.otp;
    end else begin
      fault_act = (|q_reg.faulted) | fault_in.otp;
    end
    q_next.flt_low = fault_act;

    // Shared pin: fault overrides refresh only when indicating
    if (q_reg.ctrl[CTRL_FAULT_INDICATE_ENABLE] & fault_act) begin
      q_next.rf_low = 1'b1;
    end else begin
      q_next.rf_low = ~rect_high;
    end

    // Enable pin low behaves like a fresh power-up
    if (!en_pin) begin
      q_next = rst_state();
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q_reg <= rst_state();
    end else begin
      q_reg <= q_next;
    end
  end

  // Bus answers
  assign hreadyout = (q_reg.bus != BUS_WAIT);
  assign hrdata    = q_reg.rdata;
  assign hresp     = 1'b0;

  // Drive to the sinks straight from flops
  assign drive.gate          = q_reg.gate;
  assign drive.amp           = q_reg.amplitude_code;
  assign drive.ramp_sel      = q_reg.ctrl[CTRL_RAMP_LSB +: 2];
  assign drive.short_thr_sel = q_reg.ctrl[CTRL_STH_LSB +: 2];

  // Open drain: only ever drive low, pull-up is external
  assign refresh_or_fault_pin_o  = 1'b0;
  assign refresh_or_fault_pin_oe = q_reg.rf_low;
  assign fault_out_n_o           = 1'b0;
  assign fault_out_n_oe          = q_reg.flt_low;

endmodule // ldr_ctrl

//--- ldr_host_model.sv
`timescale 1ns/1ps
module ldr_host_model (
  // Clock and slave answer
  input  wire logic        sys_clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Master request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             hang
);
  import ldr_pkg::*;
  // Quiet bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hang = 1'b0;
  end
  // Bounded so a stuck slave ends the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) hang = 1'b1;
  endtask
  // One word transfer; stale data inverted so it never looks valid
  task automatic xfer(input logic [5:0] idx, input logic wr, input logic [7:0] wd,
                      output logic [7:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {24'h0000_00, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    hwdata <= ~hwdata;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0000_00, wd};
    wait_rdy();
    rd = hrdata[7:0];
    if (wr && idx == IDX_CHOP) repeat (200) @(posedge sys_clk);
  endtask
endmodule // ldr_host_model

//--- ldr_ctrl_monitor.sv
`timescale 1ns/1ps
module ldr_ctrl_monitor #(
  parameter int OPEN_LIMIT = ldr_pkg::OPEN_CYC
) (
  // Clock and resets
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  input wire logic                   en_pin,
  // Bus
  input wire logic                   hsel,
  input wire logic [1:0]             htrans,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  // Analog side and pins
  input wire ldr_pkg::ldr_fault_in_t fault_in,
  input wire ldr_pkg::ldr_drive_t    drive,
  input wire logic                   refresh_or_fault_pin_o,
  input wire logic                   fault_out_n_o,
  input wire logic                   fault_out_n_oe
);
  import ldr_pkg::*;
  logic [19:0] cmp_run_reg;
  logic [19:0] cmp_run_next;
  // Comparator run length; saturates so a long fault never wraps
  always_comb begin
    cmp_run_next = 20'h0_0000;
    if (|fault_in.open_cmp || |fault_in.short_cmp)
      cmp_run_next = cmp_run_reg + ((&cmp_run_reg) ? 20'h0_0000 : 20'h0_0001);
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) cmp_run_reg <= 20'h0_0000;
    else cmp_run_reg <= cmp_run_next;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_wait_state: assert property (en_pin && hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state not one cycle");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_pin_reset: assert property (!en_pin |=> drive.gate == '0 && drive.amp == {NCH{6'h3F}})
    else $error("enable pin low did not reset outputs");
  a_otp_gates: assert property (fault_in.otp |=> drive.gate == '0)
    else $error("channel on during over temperature");
  a_otp_fault: assert property ((fault_in.otp && en_pin)[*4] |-> fault_out_n_oe)
    else $error("fault output not low on over temperature");
  a_fault_hold: assert property (fault_out_n_oe && fault_in.otp && en_pin |=> fault_out_n_oe)
    else $error("fault output released while condition present");
  a_fault_cause: assert property ($rose(fault_out_n_oe) |-> $past(fault_in.otp) ||
    $past(fault_in.otp, 2) || $past(cmp_run_reg) >= 20'(OPEN_LIMIT - 1))
    else $error("fault raised before comparator persistence");
  a_drain_only: assert property (refresh_or_fault_pin_o == 1'b0 && fault_out_n_o == 1'b0)
    else $error("open drain pin driven high");
endmodule // ldr_ctrl_monitor

bind ldr_ctrl ldr_ctrl_monitor #(.OPEN_LIMIT(OPEN_LIMIT)) u_mon (.sys_clk(sys_clk),
  .resetn(resetn), .en_pin(en_pin), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .fault_in(fault_in), .drive(drive),
  .refresh_or_fault_pin_o(refresh_or_fault_pin_o), .fault_out_n_o(fault_out_n_o),
  .fault_out_n_oe(fault_out_n_oe));

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import ldr_pkg::*;
  localparam int OPEN_L = 50;
  localparam int HIC_L = 600;
  localparam int PER = 16 * int'(STEP_DIV_3);
  localparam logic [5:0] D0 = 6'(IDX_CH_BASE);
  // Bench pins and bus
  logic          sys_clk;
  logic          resetn;
  logic          en_pin;
  ldr_fault_in_t fault_in;
  logic          hsel, hwrite, hreadyout, hresp, hang;
  logic [31:0]   haddr, hwdata, hrdata;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  ldr_drive_t    drive;
  logic          pin_o, pin_oe, flt_o, flt_oe;
  int            mismatches = 0;
  int            n_checks = 0;
  logic [7:0]    rd;

  ldr_host_model host (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hang(hang));
  ldr_ctrl #(.OPEN_LIMIT(OPEN_L), .HICCUP_LIMIT(HIC_L)) dut (.sys_clk(sys_clk),
    .resetn(resetn), .en_pin(en_pin), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .fault_in(fault_in),
    .drive(drive), .refresh_or_fault_pin_o(pin_o), .refresh_or_fault_pin_oe(pin_oe),
    .fault_out_n_o(flt_o), .fault_out_n_oe(flt_oe));

  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk8(string nm, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(string nm, int lo, int hi, int got);
    n_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  // Bus access; a hung slave ends the run
  task automatic bus(logic [5:0] idx, logic w, logic [7:0] d);
    host.xfer(idx, w, d, rd);
    if (hang) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic rdc(logic [5:0] idx, logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk8($sformatf("reg %h", idx), exp, rd);
  endtask
  // Counts high cycles of a gate (0), refresh pin enable (1) or fault pin enable (2)
  task automatic win(string nm, int sel, int ch, int cyc, int lo, int hi);
    int   n;
    int   nx;
    logic v;
    n  = 0;
    nx = 0;
    repeat (cyc) begin
      @(posedge sys_clk);
      v = (sel == 0 ? drive.gate[ch] : sel == 1 ? pin_oe : flt_oe);
      if (v === 1'b1) n++;
      else if (v !== 1'b0) nx++;
    end
    chk_rng(nm, lo, hi, n);
    // Unknown samples must not pass as low
    chk_rng({nm, " unknown"}, 0, 0, nx);
  endtask
  task automatic wait_flt(logic want, int lim);
    int n;
    n = 0;
    while (flt_oe !== want && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    chk_rng("fault wait", 0, lim - 1, n);
    if (n >= lim) report_and_stop();
  endtask

  task automatic t_reset_regs();
    logic [7:0] exp [13] = '{8'h01, 8'h00, 8'h01, 8'h6A, 8'hFF, 8'hFF, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h3F, 8'h0F, 8'hFF};
    for (int i = 0; i < 13; i++) rdc(6'(i), exp[i]);
    bus(6'h3F, 1'b1, 8'h5A);
    rdc(6'h3F, 8'h00);
    win("gate idle", 0, 1, 200, 0, 0);
  endtask
  task automatic t_modes();
    for (int i = 0; i < 4; i++) begin
      bus(IDX_CHOP, 1'b1, 8'(i));
      rdc(IDX_CHOP, 8'(i));
      bus(IDX_CTRL, 1'b1, 8'((i << 4) | (i << 2)));
      repeat (2) @(posedge sys_clk);
      chk8("ramp", 8'(i), {6'h00, drive.ramp_sel});
      chk8("short thr", 8'(i), {6'h00, drive.short_thr_sel});
    end
  endtask
  task automatic t_duty();
    bus(D0 + 6'h01, 1'b1, 8'h00);
    bus(D0 + 6'h02, 1'b1, 8'h00);
    bus(D0, 1'b1, 8'h15);
    bus(IDX_CHEN_LO, 1'b1, 8'hFB);
    bus(IDX_CTRL, 1'b1, 8'h01);
    repeat (3) @(posedge sys_clk);
    chk8("amp0", 8'h15, {2'b00, drive.amp[0]});
    win("gate0 zero", 0, 0, 400, 0, 0);
    win("gate1 full", 0, 1, 400, 400, 400);
    win("gate2 off", 0, 2, 400, 0, 0);
    bus(D0 + 6'h01, 1'b1, 8'h0F);
    win("gate0 low only", 0, 0, 400, 0, 0);
    bus(D0 + 6'h02, 1'b1, 8'hFF);
    repeat (2) @(posedge sys_clk);
    win("gate0 commit", 0, 0, 400, 400, 400);
    bus(D0 + 6'h01, 1'b1, 8'h00);
    win("gate0 kept", 0, 0, 400, 400, 400);
  endtask
  task automatic t_refresh();
    bus(IDX_RF_LO, 1'b1, 8'h00);
    bus(IDX_RF_HI, 1'b1, 8'h00);
    win("pin zero", 1, 0, 2 * PER, 0, 0);
    bus(IDX_RF_LO, 1'b1, 8'h02);
    win("pin low bits", 1, 0, 2 * PER, 0, 0);
    bus(IDX_RF_HI, 1'b1, 8'h00);
    win("pin rate", 1, 0, 4 * PER, 2 * PER - 16, 2 * PER + 16);
    fault_in.otp <= 1'b1;
    win("pin hidden", 1, 0, 4 * PER, 2 * PER - 16, 2 * PER + 16);
    bus(IDX_CTRL, 1'b1, 8'h81);
    repeat (3) @(posedge sys_clk);
    win("pin shown", 1, 0, 4 * PER, 4 * PER, 4 * PER);
    fault_in.otp <= 1'b0;
    wait_flt(1'b0, 10);
    rdc(IDX_RF_LO, 8'h06);
    rdc(IDX_RF_LO, 8'h02);
    bus(IDX_CTRL, 1'b1, 8'h01);
  endtask
  task automatic t_retry();
    fault_in.open_cmp[3] <= 1'b1;
    repeat (OPEN_L - 10) @(posedge sys_clk);
    fault_in.open_cmp[3] <= 1'b0;
    win("fault glitch", 2, 0, 20, 0, 0);
    fault_in.open_cmp[3] <= 1'b1;
    wait_flt(1'b1, OPEN_L + 10);
    rdc(IDX_OPEN_LO, 8'h08);
    win("probe", 0, 3, HIC_L, PROBE_CYC - 4, PROBE_CYC + 4);
    fault_in.open_cmp[3] <= 1'b0;
    wait_flt(1'b0, 2 * HIC_L);
    win("gate3 back", 0, 3, 100, 98, 100);
  endtask
  task automatic t_latch();
    bus(IDX_OPEN_LO, 1'b0, 8'h00);
    bus(IDX_CTRL, 1'b1, 8'h41);
    fault_in.short_cmp[4] <= 1'b1;
    wait_flt(1'b1, OPEN_L + 10);
    fault_in.short_cmp[4] <= 1'b0;
    win("fault held", 2, 0, 2 * HIC_L, 2 * HIC_L, 2 * HIC_L);
    win("gate4 latched", 0, 4, HIC_L, 0, 0);
    rdc(IDX_SHORT_LO, 8'h10);
    wait_flt(1'b0, 10);
    rdc(IDX_SHORT_LO, 8'h00);
    win("gate4 still off", 0, 4, 100, 0, 0);
    en_pin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    en_pin <= 1'b1;
    bus(IDX_CTRL, 1'b1, 8'h01);
    repeat (2) @(posedge sys_clk);
    win("gate4 freed", 0, 4, 100, 100, 100);
  endtask
  // Pin reset restarts the period counter, so channel 1 timing is known
  task automatic t_stagger();
    en_pin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    en_pin <= 1'b1;
    bus(D0 + 6'h04, 1'b1, 8'h08);
    bus(D0 + 6'h05, 1'b1, 8'h02);
    bus(IDX_CTRL, 1'b1, 8'h03);
    win("gate1 staggered", 0, 1, 600, 0, 0);
    win("gate1 late", 0, 1, 1000, STAGGER_STEPS * int'(STEP_DIV_1) - 2,
        STAGGER_STEPS * int'(STEP_DIV_1) + 2);
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    en_pin = 1'b1;
    fault_in = '0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset_regs();
    t_modes();
    t_duty();
    t_refresh();
    t_retry();
    t_latch();
    t_stagger();
    report_and_stop();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end
endmodule // tb_top
